// *** core/modbus_measurement_responder.sv ***
// Serial slave that answers holding-register reads of the four measurement channels.
`timescale 1ns/1ps
module modbus_measurement_responder #(
	parameter int          BIT_CYCLES = modbus_resp_pkg::BIT_CYCLES,
	parameter int          IFG_CYCLES = modbus_resp_pkg::IFG_CYCLES,
	parameter logic [15:0] MAX_QTY    = modbus_resp_pkg::MAX_QTY_DEF
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        rs485_rx_i,
	output logic             rs485_tx_o,
	output logic             rs485_de_o,
	input  wire logic [7:0]  serial_tail_bcd_i,
	input  wire logic [31:0] flow_value_i,
	input  wire logic [31:0] consumption_i,
	input  wire logic [31:0] reverse_consumption_i,
	input  wire logic        flow_reversed_i,
	output logic             busy_o
);
	localparam int IW = $clog2(IFG_CYCLES + 1);

	if (IFG_CYCLES < 2 || BIT_CYCLES < 4) begin : g_chk_time
		$error("modbus_measurement_responder: timing counts too small");
	end
	if (MAX_QTY == 16'h0000 || MAX_QTY > modbus_resp_pkg::MAX_QTY_DEF) begin : g_chk_qty
		$error("modbus_measurement_responder: MAX_QTY out of range");
	end

	typedef enum logic [2:0] {
		ST_LISTEN = 3'b001,
		ST_SEND   = 3'b010,
		ST_FLUSH  = 3'b100
	} resp_state_t;

	typedef struct packed {
		resp_state_t     st;
		logic [7:0][7:0] req;
		logic [3:0]      rx_cnt;
		logic            rx_bad;
		logic [15:0]     rx_crc;
		logic [IW-1:0]   idle;
		logic [7:0]      addr;
		logic            exc;
		logic [7:0]      field;
		logic [15:0]     start;
		logic [7:0]      len;
		logic [7:0]      idx;
		logic [15:0]     tx_crc;
		logic [31:0]     flow;
		logic [31:0]     cons;
		logic [31:0]     rev;
		logic            dir;
	} resp_regs_t;

	resp_regs_t s_r;
	resp_regs_t s_nxt;

	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_ferr;
	logic       tx_ready;
	logic       tx_valid;
	logic [7:0] tx_byte;

	rtu_uart #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_uart (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.rx_i       (rs485_rx_i),
		.rx_valid_o (rx_valid),
		.rx_data_o  (rx_data),
		.rx_ferr_o  (rx_ferr),
		.tx_valid_i (tx_valid),
		.tx_data_i  (tx_byte),
		.tx_ready_o (tx_ready),
		.tx_o       (rs485_tx_o)
	);

	// One 16-bit register of the snapshot, 32-bit values low word first.
	function automatic logic [15:0] reg_word(input resp_regs_t s, input logic [15:0] r);
		logic [15:0] w;
		w = 16'h0000;
		case (r)
			modbus_resp_pkg::REG_FLOW_LO: w = s.flow[15:0];
			modbus_resp_pkg::REG_FLOW_HI: w = s.flow[31:16];
			modbus_resp_pkg::REG_CONS_LO: w = s.cons[15:0];
			modbus_resp_pkg::REG_CONS_HI: w = s.cons[31:16];
			modbus_resp_pkg::REG_REV_LO:  w = s.rev[15:0];
			modbus_resp_pkg::REG_REV_HI:  w = s.rev[31:16];
			modbus_resp_pkg::REG_DIR_LO: begin
				w = s.dir ? modbus_resp_pkg::DIR_REVERSE : modbus_resp_pkg::DIR_FORWARD;
			end
			modbus_resp_pkg::REG_DIR_HI:  w = modbus_resp_pkg::DIR_FORWARD;
			default:                      w = 16'h0000;
		endcase
		return w;
	endfunction : reg_word

	// Byte number idx of the reply frame, including the trailing check bytes.
	always_comb begin
		logic [7:0]  k;
		logic [15:0] w;
		k = s_r.idx - modbus_resp_pkg::HDR_LEN;
		w = reg_word(s_r, s_r.start + {8'h00, 1'b0, k[7:1]});
		if (s_r.idx == 8'h00) begin
			tx_byte = s_r.addr;
		end else if (s_r.idx == 8'h01) begin
			tx_byte = s_r.exc ? (modbus_resp_pkg::FC_READ_HOLDING | modbus_resp_pkg::EXC_FLAG)
					: modbus_resp_pkg::FC_READ_HOLDING;
		end else if (s_r.idx == 8'h02) begin
			tx_byte = s_r.field;
		end else if (s_r.idx == s_r.len - modbus_resp_pkg::CRC_LEN) begin
			tx_byte = s_r.tx_crc[7:0];
		end else if (s_r.idx == s_r.len - 8'h01) begin
			tx_byte = s_r.tx_crc[15:8];
		end else begin
			tx_byte = k[0] ? w[7:0] : w[15:8];
		end
	end

	assign tx_valid = (s_r.st == ST_SEND);

	always_comb begin
		logic [7:0]  own;
		logic [15:0] qty;
		logic        frame_end;
		s_nxt = s_r;
		own = modbus_resp_pkg::bcd_to_addr(serial_tail_bcd_i);
		qty = {s_r.req[4], s_r.req[5]};
		frame_end = 1'b0;
		case (s_r.st)
			ST_LISTEN: begin
				if (rx_valid || rx_ferr) begin
					s_nxt.idle = '0;
					s_nxt.rx_crc = modbus_resp_pkg::crc16_byte(s_r.rx_crc, rx_data);
					s_nxt.rx_bad = s_r.rx_bad | rx_ferr;
					if (s_r.rx_cnt < modbus_resp_pkg::REQ_LEN) begin
						s_nxt.req[s_r.rx_cnt[2:0]] = rx_data;
						s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
					end else begin
						// An overlong frame is not a read request.
						s_nxt.rx_cnt = modbus_resp_pkg::REQ_OVERFLOW;
					end
				end else if (s_r.idle != IW'(IFG_CYCLES)) begin
					s_nxt.idle = s_r.idle + IW'(1);
					frame_end = (s_r.idle == IW'(IFG_CYCLES - 1)) && (s_r.rx_cnt != 4'h0);
				end
				if (frame_end) begin
					s_nxt.rx_cnt = 4'h0;
					s_nxt.rx_bad = 1'b0;
					s_nxt.rx_crc = modbus_resp_pkg::CRC_INIT;
					if (!s_r.rx_bad && s_r.rx_cnt == modbus_resp_pkg::REQ_LEN &&
						s_r.rx_crc == modbus_resp_pkg::CRC_RESIDUE &&
						s_r.req[0] == own) begin
						// Snapshot keeps both halves of every 32-bit value coherent.
						s_nxt.flow = flow_value_i;
						s_nxt.cons = consumption_i;
						s_nxt.rev = reverse_consumption_i;
						s_nxt.dir = flow_reversed_i;
						s_nxt.addr = own;
						s_nxt.start = {s_r.req[2], s_r.req[3]};
						s_nxt.idx = 8'h00;
						s_nxt.tx_crc = modbus_resp_pkg::CRC_INIT;
						s_nxt.st = ST_SEND;
						if (s_r.req[1] != modbus_resp_pkg::FC_READ_HOLDING) begin
							s_nxt.exc = 1'b1;
							s_nxt.field = modbus_resp_pkg::EXC_ILLEGAL_FUNC;
							s_nxt.len = modbus_resp_pkg::REPLY_EXC_LEN;
						end else if (qty == 16'h0000 || qty > MAX_QTY) begin
							s_nxt.exc = 1'b1;
							s_nxt.field = modbus_resp_pkg::EXC_ILLEGAL_VALUE;
							s_nxt.len = modbus_resp_pkg::REPLY_EXC_LEN;
						end else begin
							s_nxt.exc = 1'b0;
							s_nxt.field = {qty[6:0], 1'b0};
							s_nxt.len = modbus_resp_pkg::HDR_LEN + {qty[6:0], 1'b0} +
									modbus_resp_pkg::CRC_LEN;
						end
					end
				end
			end
			ST_SEND: begin
				// Incoming bytes are ignored, so one request is served at a time.
				if (tx_ready) begin
					if (s_r.idx < s_r.len - modbus_resp_pkg::CRC_LEN) begin
						s_nxt.tx_crc = modbus_resp_pkg::crc16_byte(s_r.tx_crc, tx_byte);
					end
					s_nxt.idx = s_r.idx + 8'h01;
					if (s_r.idx == s_r.len - 8'h01) begin
						s_nxt.st = ST_FLUSH;
					end
				end
			end
			ST_FLUSH: begin
				// The driver stays on until the last stop bit has left the line.
				if (tx_ready) begin
					s_nxt.st = ST_LISTEN;
					s_nxt.idle = '0;
					s_nxt.rx_cnt = 4'h0;
					s_nxt.rx_bad = 1'b0;
					s_nxt.rx_crc = modbus_resp_pkg::CRC_INIT;
				end
			end
			default: begin
				s_nxt.st = ST_LISTEN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.st <= ST_LISTEN;
			s_r.rx_crc <= modbus_resp_pkg::CRC_INIT;
			s_r.tx_crc <= modbus_resp_pkg::CRC_INIT;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rs485_de_o = (s_r.st != ST_LISTEN);
	assign busy_o = (s_r.st != ST_LISTEN);

endmodule : modbus_measurement_responder

// *** core/modbus_resp_pkg.sv ***
// Constants shared by the measurement responder and its serial byte engine.
package modbus_resp_pkg;

	// Clock and serial timing.
	localparam int CLK_HZ        = 125_000_000;
	localparam int BAUD_RATE     = 19200;
	localparam int CHAR_BITS     = 10;
	localparam int IFG_CHARS     = 7;
	localparam int RESP_DELAY_MS = 0;
	localparam int BIT_CYCLES    = CLK_HZ / BAUD_RATE;
	localparam int IFG_CYCLES    = BIT_CYCLES * CHAR_BITS * IFG_CHARS;
	localparam int DATA_BITS     = 8;

	// Request and reply framing.
	localparam logic [3:0]  REQ_LEN        = 4'h8;
	localparam logic [3:0]  REQ_OVERFLOW   = 4'h9;
	localparam logic [7:0]  HDR_LEN        = 8'h03;
	localparam logic [7:0]  CRC_LEN        = 8'h02;
	localparam logic [7:0]  REPLY_EXC_LEN  = 8'h05;
	localparam logic [15:0] CRC_INIT       = 16'hFFFF;
	localparam logic [15:0] CRC_POLY       = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE    = 16'h0000;
	localparam logic [15:0] MAX_QTY_DEF    = 16'h007D;

	// Function and exception codes.
	localparam logic [7:0] FC_READ_HOLDING   = 8'h03;
	localparam logic [7:0] EXC_FLAG          = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

	// Register indices of the measurement channels.
	localparam logic [15:0] REG_FLOW_LO = 16'h0006;
	localparam logic [15:0] REG_FLOW_HI = 16'h0007;
	localparam logic [15:0] REG_CONS_LO = 16'h0008;
	localparam logic [15:0] REG_CONS_HI = 16'h0009;
	localparam logic [15:0] REG_REV_LO  = 16'h000E;
	localparam logic [15:0] REG_REV_HI  = 16'h000F;
	localparam logic [15:0] REG_DIR_LO  = 16'h002A;
	localparam logic [15:0] REG_DIR_HI  = 16'h002B;

	// Flow direction values.
	localparam logic [15:0] DIR_FORWARD = 16'h0000;
	localparam logic [15:0] DIR_REVERSE = 16'h0001;

	// One step of the reflected CRC-16 used on the serial link.
	function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < DATA_BITS; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc16_byte

	// Two packed decimal digits to a binary bus address.
	function automatic logic [7:0] bcd_to_addr(input logic [7:0] bcd);
		return 8'({4'h0, bcd[7:4]} * 8'h0A + {4'h0, bcd[3:0]});
	endfunction : bcd_to_addr

endpackage : modbus_resp_pkg

// *** core/rtu_uart.sv ***
// Serial byte engine, 8 data bits, no parity, one stop bit, for the RS-485 link.
`timescale 1ns/1ps
module rtu_uart #(
	parameter int BIT_CYCLES = modbus_resp_pkg::BIT_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       rx_i,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_ferr_o,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            tx_o
);
	localparam int CW = $clog2(BIT_CYCLES);

	if (BIT_CYCLES < 4) begin : g_chk
		$error("rtu_uart: BIT_CYCLES too small");
	end

	typedef struct packed {
		logic [1:0]    sync;
		logic          rx_busy;
		logic [CW-1:0] rx_cnt;
		logic [3:0]    rx_bit;
		logic [7:0]    rx_sh;
		logic          rx_valid;
		logic          rx_ferr;
		logic [7:0]    rx_data;
		logic          tx_busy;
		logic [CW-1:0] tx_cnt;
		logic [3:0]    tx_bits;
		logic [8:0]    tx_sh;
		logic          tx_line;
	} uart_state_t;

	uart_state_t s_r;
	uart_state_t s_nxt;

	logic line;

	always_comb begin
		s_nxt = s_r;
		line = s_r.sync[1];
		s_nxt.sync = {s_r.sync[0], rx_i};
		s_nxt.rx_valid = 1'b0;
		s_nxt.rx_ferr = 1'b0;
		if (!s_r.rx_busy) begin
			if (!line) begin
				s_nxt.rx_busy = 1'b1;
				s_nxt.rx_cnt = CW'(BIT_CYCLES / 2);
				s_nxt.rx_bit = 4'h0;
			end
		end else if (s_r.rx_cnt != '0) begin
			s_nxt.rx_cnt = s_r.rx_cnt - CW'(1);
		end else begin
			s_nxt.rx_cnt = CW'(BIT_CYCLES - 1);
			if (s_r.rx_bit == 4'h0) begin
				// A start bit that is gone by mid-bit was a glitch.
				s_nxt.rx_busy = ~line;
				s_nxt.rx_bit = 4'h1;
			end else if (s_r.rx_bit <= 4'(modbus_resp_pkg::DATA_BITS)) begin
				s_nxt.rx_sh = {line, s_r.rx_sh[7:1]};
				s_nxt.rx_bit = s_r.rx_bit + 4'h1;
			end else begin
				s_nxt.rx_busy = 1'b0;
				s_nxt.rx_valid = line;
				s_nxt.rx_ferr = ~line;
				s_nxt.rx_data = s_r.rx_sh;
			end
		end
		if (!s_r.tx_busy) begin
			s_nxt.tx_line = 1'b1;
			if (tx_valid_i) begin
				s_nxt.tx_busy = 1'b1;
				s_nxt.tx_line = 1'b0;
				s_nxt.tx_sh = {1'b1, tx_data_i};
				s_nxt.tx_bits = 4'(modbus_resp_pkg::CHAR_BITS - 1);
				s_nxt.tx_cnt = CW'(BIT_CYCLES - 1);
			end
		end else if (s_r.tx_cnt != '0) begin
			s_nxt.tx_cnt = s_r.tx_cnt - CW'(1);
		end else if (s_r.tx_bits == 4'h0) begin
			s_nxt.tx_busy = 1'b0;
		end else begin
			s_nxt.tx_line = s_r.tx_sh[0];
			s_nxt.tx_sh = {1'b1, s_r.tx_sh[8:1]};
			s_nxt.tx_bits = s_r.tx_bits - 4'h1;
			s_nxt.tx_cnt = CW'(BIT_CYCLES - 1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.sync <= 2'h3;
			s_r.tx_line <= 1'b1;
			s_r.tx_sh <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_valid_o = s_r.rx_valid;
	assign rx_data_o = s_r.rx_data;
	assign rx_ferr_o = s_r.rx_ferr;
	assign tx_ready_o = ~s_r.tx_busy;
	assign tx_o = s_r.tx_line;

endmodule : rtu_uart

// *** tb/modbus_master_model.sv ***
// Serial bus master model that sends read requests and collects reply bytes.
`timescale 1ns/1ps
module modbus_master_model #(
	parameter int BIT_CYCLES = 8
) (
	input  wire logic clk_i,
	input  wire logic tx_line_i,
	output logic      rx_line_o
);
	// The line is biased high when idle, so the model holds it high between frames.
	initial rx_line_o = 1'b1;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		c = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction : crc_step

	task automatic put_byte(input logic [7:0] b);
		logic [9:0] s;
		s = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			#1 rx_line_o = s[i];
			repeat (BIT_CYCLES - 1) @(posedge clk_i);
		end
	endtask : put_byte

	// The caller waits for each reply before the next request, one at a time.
	task automatic send_frame(input logic [7:0] a, fc, input logic [15:0] st, q,
			input logic bad);
		logic [7:0]  f[8];
		logic [15:0] c;
		f = '{a, fc, st[15:8], st[7:0], q[15:8], q[7:0], 8'h00, 8'h00};
		c = 16'hFFFF;
		for (int i = 0; i < 6; i++) begin
			c = crc_step(c, f[i]);
		end
		f[6] = c[7:0];
		f[7] = c[15:8] ^ {7'h00, bad};
		for (int i = 0; i < 8; i++) begin
			put_byte(f[i]);
		end
	endtask : send_frame

	// Bits are read at the falling clock edge, where the registered line is settled.
	task automatic get_byte(output logic [7:0] b, output logic ok);
		ok = 1'b0;
		b = 8'h00;
		for (int n = 0; n < 1000 && !ok; n++) begin
			@(negedge clk_i);
			ok = (tx_line_i === 1'b0);
		end
		if (ok) begin
			repeat (BIT_CYCLES / 2) @(negedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(negedge clk_i);
				b[i] = tx_line_i;
			end
			repeat (BIT_CYCLES) @(negedge clk_i);
		end
	endtask : get_byte
endmodule : modbus_master_model

// *** tb/modbus_measurement_responder_chk.sv ***
// Assertions on the serial reply timing of the measurement responder.
`timescale 1ns/1ps
module modbus_measurement_responder_chk #(
	parameter int BIT_CYCLES = 8,
	parameter int IFG_CYCLES = 560
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic rs485_rx_i,
	input wire logic rs485_tx_o,
	input wire logic rs485_de_o,
	input wire logic busy_o
);
	logic [31:0] quiet_r;
	logic [31:0] low_r;
	logic [31:0] high_r;
	logic [31:0] de_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// Run lengths let bit timing be checked without long repetition counts.
	always_ff @(posedge clk_i) begin
		quiet_r <= (sys_rst_i || !rs485_rx_i) ? 32'h0 : quiet_r + 32'h1;
		low_r   <= (sys_rst_i || rs485_tx_o) ? 32'h0 : low_r + 32'h1;
		high_r  <= (sys_rst_i || !rs485_tx_o) ? 32'h0 : high_r + 32'h1;
		de_r    <= (sys_rst_i || !rs485_de_o) ? 32'h0 : de_r + 32'h1;
	end

	sequence reply_start;
		$rose(rs485_de_o);
	endsequence
	sequence reply_end;
		$fell(rs485_de_o);
	endsequence

	a_busy_with_de: assert property (busy_o == rs485_de_o)
		else $error("busy differs from driver enable");
	a_idle_line_high: assert property (!rs485_de_o |-> rs485_tx_o)
		else $error("line low while driver off");
	a_start_with_de: assert property (reply_start |=> !rs485_tx_o)
		else $error("reply does not open with a start bit");
	a_gap_before_reply: assert property (reply_start |-> quiet_r >= IFG_CYCLES)
		else $error("reply before the frame gap");
	a_no_reply_delay: assert property (reply_start |-> quiet_r <= IFG_CYCLES + 10 * BIT_CYCLES)
		else $error("reply started late");
	a_low_bit_length: assert property ($rose(rs485_tx_o) && rs485_de_o |-> low_r % BIT_CYCLES == 0)
		else $error("low bit run not a whole bit time");
	a_stop_before_off: assert property (reply_end |-> high_r >= BIT_CYCLES)
		else $error("driver released inside the stop bit");
	a_reply_min_len: assert property (reply_end |-> de_r >= 50 * BIT_CYCLES)
		else $error("reply shorter than five characters");
endmodule : modbus_measurement_responder_chk

bind modbus_measurement_responder modbus_measurement_responder_chk #(
	.BIT_CYCLES(BIT_CYCLES),
	.IFG_CYCLES(IFG_CYCLES)
) chk_u (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.rs485_rx_i(rs485_rx_i),
	.rs485_tx_o(rs485_tx_o),
	.rs485_de_o(rs485_de_o),
	.busy_o(busy_o)
);

// *** tb/tb_modbus_measurement_responder.sv ***
// Self-checking bench that polls the measurement responder over its serial link.
`timescale 1ns/1ps
module tb_modbus_measurement_responder;
	localparam int BC = 8;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        rx_w;
	logic        tx_w;
	logic        de_w;
	logic        busy_w;
	logic [7:0]  tail = 8'h42;
	logic [31:0] flow = 32'h4148CCCD;
	logic [31:0] cons = 32'h12345678;
	logic [31:0] rev = 32'h9ABCDEF0;
	logic        dir = 1'b0;
	int          err_count = 0;
	int          checks = 0;
	logic [7:0]  rb;
	logic        rok;

	always #4 clk_i = ~clk_i;

	modbus_measurement_responder #(
		.BIT_CYCLES(BC),
		.IFG_CYCLES(BC * 70)
	) dut_u (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.rs485_rx_i(rx_w),
		.rs485_tx_o(tx_w),
		.rs485_de_o(de_w),
		.serial_tail_bcd_i(tail),
		.flow_value_i(flow),
		.consumption_i(cons),
		.reverse_consumption_i(rev),
		.flow_reversed_i(dir),
		.busy_o(busy_w)
	);

	modbus_master_model #(.BIT_CYCLES(BC)) m_u (
		.clk_i(clk_i),
		.tx_line_i(tx_w),
		.rx_line_o(rx_w)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	function automatic logic [15:0] regv(input int n);
		case (n)
			6: return flow[15:0];
			7: return flow[31:16];
			8: return cons[15:0];
			9: return cons[31:16];
			14: return rev[15:0];
			15: return rev[31:16];
			42: return {15'h0000, dir};
			default: return 16'h0000;
		endcase
	endfunction : regv

	task automatic run(input logic [7:0] tl, a, fc, input int st, q, input logic d, bad, hit);
		logic [7:0]  e[$];
		logic [7:0]  b;
		logic        ok;
		logic [15:0] c;
		@(posedge clk_i);
		#1 tail = tl;
		dir = d;
		e.delete();
		e.push_back(a);
		if (fc != modbus_resp_pkg::FC_READ_HOLDING) begin
			e.push_back(modbus_resp_pkg::FC_READ_HOLDING | modbus_resp_pkg::EXC_FLAG);
			e.push_back(modbus_resp_pkg::EXC_ILLEGAL_FUNC);
		end else if (q == 0 || q > int'(modbus_resp_pkg::MAX_QTY_DEF)) begin
			e.push_back(modbus_resp_pkg::FC_READ_HOLDING | modbus_resp_pkg::EXC_FLAG);
			e.push_back(modbus_resp_pkg::EXC_ILLEGAL_VALUE);
		end else begin
			e.push_back(fc);
			e.push_back(8'(2 * q));
			for (int i = st; i < st + q; i++) begin
				c = regv(i);
				e.push_back(c[15:8]);
				e.push_back(c[7:0]);
			end
		end
		m_u.send_frame(a, fc, 16'(st), 16'(q), bad);
		c = 16'hFFFF;
		for (int i = 0; i < (hit ? e.size() + 2 : 1); i++) begin
			m_u.get_byte(b, ok);
			check(16'(ok), 16'(hit));
			if (i == 0) begin
				check(16'(busy_w), 16'(hit));
			end
			if (ok !== hit)
				tally_and_finish();
			if (hit && i < e.size())
				check(16'(b), 16'(e[i]));
			c = m_u.crc_step(c, b);
		end
		if (hit)
			check(c, 16'h0000);
		// The driver enable is looked at on the falling edge, away from the edge that moves it.
		for (int n = 0; n < 200 && de_w !== 1'b0; n++) begin
			@(negedge clk_i);
		end
		check(16'(de_w), 16'h0000);
		check(16'(busy_w), 16'h0000);
		if (de_w !== 1'b0) begin
			tally_and_finish();
		end
		$display("test done addr=%h fc=%h start=%0d qty=%0d", a, fc, st, q);
	endtask : run

	initial begin
		repeat (10) @(posedge clk_i);
		#1 sys_rst_i = 1'b0;
		run(8'h42, 8'h2A, 8'h03, 6, 10, 1'b0, 1'b0, 1'b1);
		run(8'h42, 8'h2A, 8'h03, 42, 2, 1'b1, 1'b0, 1'b1);
		run(8'h42, 8'h2A, 8'h03, 42, 2, 1'b0, 1'b0, 1'b1);
		run(8'h19, 8'h13, 8'h03, 8, 2, 1'b0, 1'b0, 1'b1);
		run(8'h19, 8'h2A, 8'h03, 8, 2, 1'b0, 1'b0, 1'b0);
		run(8'h19, 8'h13, 8'h03, 8, 2, 1'b0, 1'b1, 1'b0);
		run(8'h19, 8'h13, 8'h04, 8, 2, 1'b0, 1'b0, 1'b1);
		run(8'h19, 8'h13, 8'h03, 8, 0, 1'b0, 1'b0, 1'b1);
		// A reset in mid-reply must silence the driver and leave the line idle.
		m_u.send_frame(8'h13, modbus_resp_pkg::FC_READ_HOLDING, 16'h0008, 16'h0002, 1'b0);
		m_u.get_byte(rb, rok);
		check(16'(rok), 16'h0001);
		@(posedge clk_i);
		#1 sys_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1 check(16'(tx_w), 16'h0001);
		check(16'(de_w), 16'h0000);
		check(16'(busy_w), 16'h0000);
		sys_rst_i = 1'b0;
		$display("test done mid-reply reset");
		run(8'h19, 8'h13, 8'h03, 14, 2, 1'b1, 1'b0, 1'b1);
		tally_and_finish();
	end
endmodule : tb_modbus_measurement_responder
